// ### include/ocp_cfg.svh
// Offsets, field positions, reset values and counts of the cache port
`ifndef OCP_CFG_SVH
`define OCP_CFG_SVH

// ==========================================
// Register offsets (byte addresses)
`define OCP_ADDR_CTRL 4'h0
`define OCP_ADDR_STATUS 4'h4

// ==========================================
// Control register fields
`define OCP_F_CACHE_ON 0
`define OCP_F_SIZE_LO 1
`define OCP_F_BANK 5
`define OCP_F_BURST 6
`define OCP_F_ALT 7
`define OCP_F_DUAL 8
`define OCP_F_RATIO_LO 9
`define OCP_F_WRRD_LO 16
`define OCP_F_RDWR_LO 24

// ==========================================
// Control register reset value
`define OCP_CTRL_RESET 32'h0203_0804

// ==========================================
// Spacing counts in core clock cycles, single-data special ratio in halves, last beat number
`define OCP_RDWR_BASE 10'h006
`define OCP_RDWR_ZERO 10'h040
`define OCP_SINCE_MAX 10'h3ff
`define OCP_SD_SPECIAL_X2 4'h4
`define OCP_LAST_BEAT 2'h3

`endif

// ### include/ocp_pkg.sv
// Types shared by the cache port control files
package ocp_pkg;

  // Transaction sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_BEAT = 4'b0100,
    ST_TAIL = 4'b1000
  } ocp_state_type;

  // Beat position handed to the strobe generator
  typedef struct packed {
    logic active;
    logic write;
    logic tail;
    logic [1:0] beat;
  } ocp_phase_type;

  // Active-low control pins toward the SRAM arrays
  typedef struct packed {
    logic load_strobe_n;
    logic data_oe_n;
    logic data_write_n;
    logic tag_oe_n;
    logic tag_write_n;
  } ocp_strobe_type;

  // Cache transaction request
  typedef struct packed {
    logic write;
    logic [19:0] index;
  } ocp_req_type;

  // Decoded configuration
  typedef struct packed {
    logic cache_on;
    logic [3:0] cache_size_sel;
    logic bank_split_on;
    logic burst_sel;
    logic alt_strobe_style;
    logic dual_data;
    logic [3:0] ratio_x2;
    logic [3:0] wr_to_rd_gap_cfg;
    logic [5:0] rd_to_wr_gap_cfg;
  } ocp_cfg_type;

endpackage

// ### logic/ocp_strobe_gen.sv
// Per-beat strobe pattern generator for the four SRAM styles
`timescale 1ns/10ps
`default_nettype none

module ocp_strobe_gen (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Style select and beat position
  input wire logic alt_strobe_style,
  input wire logic burst_sel,
  input wire ocp_pkg::ocp_phase_type phase,
  // Control pins
  output ocp_pkg::ocp_strobe_type strobe
);

  logic rd_beat;
  logic wr_beat;
  logic rd_tail;
  logic wr_tail;
  logic first;
  ocp_pkg::ocp_strobe_type strobe_d;
  ocp_pkg::ocp_strobe_type strobe_q;

  assign rd_beat = phase.active && !phase.write;
  assign wr_beat = phase.active && phase.write;
  assign rd_tail = phase.tail && !phase.write;
  assign wr_tail = phase.tail && phase.write;
  assign first = phase.beat == 2'h0;

  // ==========================================
  // Pattern table
  always_comb begin
    strobe_d.load_strobe_n = 1'b1;
    strobe_d.data_write_n = 1'b1;
    strobe_d.tag_write_n = !(wr_beat && first);
    unique case ({alt_strobe_style, burst_sel})
      2'b00: begin
        // Style A, enables act as chip selects
        strobe_d.data_oe_n = !(rd_beat || wr_beat);
        strobe_d.data_write_n = !(wr_beat || wr_tail);
        strobe_d.tag_oe_n = !((rd_beat || wr_beat) && first);
      end
      2'b01: begin
        // Style B, enables act as chip selects
        strobe_d.load_strobe_n = !((rd_beat || wr_beat) && first);
        strobe_d.data_oe_n = !(rd_beat || wr_beat || wr_tail);
        strobe_d.data_write_n = rd_beat;
        strobe_d.tag_oe_n = !((rd_beat || wr_beat) && first);
      end
      2'b10: begin
        // Style C, read enable stretched over the tail
        strobe_d.data_oe_n =
          !(((rd_beat || wr_beat) && !first) || rd_tail);
        strobe_d.tag_oe_n = !(rd_beat && phase.beat <= 2'h1);
      end
      2'b11: begin
        // Style D, read enable stretched over the tail
        strobe_d.load_strobe_n = !((rd_beat || wr_beat) && first);
        strobe_d.data_oe_n = !((rd_beat && !first) || rd_tail);
        strobe_d.data_write_n = !wr_beat;
        strobe_d.tag_oe_n =
          !(rd_beat && (phase.beat == 2'h1 || phase.beat == 2'h2));
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_q <= 5'h1f;
    end else begin
      strobe_q <= strobe_d;
    end
  end

  assign strobe = strobe_q;

  // ==========================================
  // Checks
  property p_tag_write_first;
    @(posedge core_clk) disable iff (!rst_n)
      (wr_beat && first) |=> !strobe.tag_write_n;
  endproperty
  a_tag_write_first: assert property (p_tag_write_first)
    else $error("tag write strobe missing on first write beat");

  property p_style_a_load;
    @(posedge core_clk) disable iff (!rst_n)
      (!alt_strobe_style && !burst_sel) |=> strobe.load_strobe_n;
  endproperty
  a_style_a_load: assert property (p_style_a_load)
    else $error("load strobe low in style A");

  property p_style_c_rd_tail;
    @(posedge core_clk) disable iff (!rst_n)
      (alt_strobe_style && rd_tail) |=> !strobe.data_oe_n;
  endproperty
  a_style_c_rd_tail: assert property (p_style_c_rd_tail)
    else $error("read enable not stretched over read tail");

  property p_idle_tags;
    @(posedge core_clk) disable iff (!rst_n)
      (!phase.active && !phase.tail) |=>
        (strobe.tag_oe_n && strobe.tag_write_n);
  endproperty
  a_idle_tags: assert property (p_idle_tags)
    else $error("tag strobes active while idle");

endmodule

`default_nettype wire

// ### logic/ocp_port_ctrl.sv
// Cache port control: register slave, spacing, index and beat sequencing
//
// Contract
// - Write-to-read spacing is (write-to-read gap minus one) times frame count.
// - Single-data ratio 2.0 uses gap minus two times frame count.
// - Read-to-write spacing is the read-to-write gap plus six cycles.
// - A read-to-write gap of zero means 64 cycles.
// - Index output is 20 bits, address bits 23 to 4, 1MB to 16MB.
// - Without banking, index bits above the cache size stay zero.
// - With banking, next index bit above the top carries its inverse.
// - Style from burst select and alternate bit; alternate one unsupported. The code flags it in status bit 2 but still drives its pattern.
// - Style A strobe pattern per beat.
// - Style B strobe pattern per beat.
// - Style C strobe pattern per beat.
// - Style D strobe pattern per beat.
// - Styles A and B use output enables as chip selects.
// - Styles C and D stretch output enables one cycle past read data.
// - Ratio is core cycles per peak 16-byte transfer, in halves.
// - Frame count: dual twice ratio; single ratio if even else twice.
// - Every transfer is four beats with the tag accessed on beat one; style C reads also use beat two, style D reads beats two and three.
//
// Decided for this implementation: the Wishbone slave port and the address map.
`include "ocp_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module ocp_port_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Transaction requests
  input wire logic req_valid,
  input wire ocp_pkg::ocp_req_type req,
  output logic req_ready,
  // Cache clock from the link
  input wire logic link_clk,
  // SRAM pins
  output logic [19:0] cache_index_out,
  output ocp_pkg::ocp_strobe_type strobe,
  // Status
  output logic busy
);

  // ==========================================
  // Reset release
  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ==========================================
  // Link clock edge detection
  logic lclk_s1_q;
  logic lclk_s2_q;
  logic lclk_s3_q;
  logic link_rise;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lclk_s1_q <= 1'b0;
      lclk_s2_q <= 1'b0;
      lclk_s3_q <= 1'b0;
    end else begin
      lclk_s1_q <= link_clk;
      lclk_s2_q <= lclk_s1_q;
      lclk_s3_q <= lclk_s2_q;
    end
  end

  assign link_rise = lclk_s2_q && !lclk_s3_q;

  // ==========================================
  // Register file
  logic [31:0] ctrl_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic bus_access;
  logic unsupported;
  logic last_write_q;
  logic [31:0] status_word;
  ocp_pkg::ocp_cfg_type cfg;

  assign bus_access = wb_cyc_i && wb_stb_i && !ack_q;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= `OCP_CTRL_RESET;
    end else if (bus_access && wb_we_i && wb_adr_i == `OCP_ADDR_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          ctrl_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_access;
    end
  end

  always_comb begin
    status_word = 32'h0;
    status_word[0] = busy;
    status_word[1] = last_write_q;
    status_word[2] = unsupported;
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 32'h0;
    end else if (bus_access && !wb_we_i) begin
      unique case (wb_adr_i)
        `OCP_ADDR_CTRL: rdata_q <= ctrl_q;
        `OCP_ADDR_STATUS: rdata_q <= status_word;
        default: rdata_q <= 32'h0;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // Field decode
  always_comb begin
    cfg.cache_on = ctrl_q[`OCP_F_CACHE_ON];
    cfg.cache_size_sel = ctrl_q[`OCP_F_SIZE_LO +: 4];
    cfg.bank_split_on = ctrl_q[`OCP_F_BANK];
    cfg.burst_sel = ctrl_q[`OCP_F_BURST];
    cfg.alt_strobe_style = ctrl_q[`OCP_F_ALT];
    cfg.dual_data = ctrl_q[`OCP_F_DUAL];
    cfg.ratio_x2 = ctrl_q[`OCP_F_RATIO_LO +: 4];
    cfg.wr_to_rd_gap_cfg = ctrl_q[`OCP_F_WRRD_LO +: 4];
    cfg.rd_to_wr_gap_cfg = ctrl_q[`OCP_F_RDWR_LO +: 6];
  end

  // Alternate style is flagged but still driven with its pattern
  assign unsupported = cfg.alt_strobe_style;

  // ==========================================
  // Spacing computation
  logic [3:0] frame_cnt;
  logic sd_special;
  logic [3:0] wr_sub;
  logic [9:0] wr_rd_need;
  logic [9:0] rd_wr_need;

  always_comb begin
    if (cfg.dual_data) begin
      frame_cnt = cfg.ratio_x2;
    end else if (cfg.ratio_x2[1:0] == 2'b00) begin
      frame_cnt = {1'b0, cfg.ratio_x2[3:1]};
    end else begin
      frame_cnt = cfg.ratio_x2;
    end
  end

  assign sd_special = !cfg.dual_data &&
                      cfg.ratio_x2 == `OCP_SD_SPECIAL_X2;

  // Settings at or below the subtrahend give no spacing at all
  always_comb begin
    wr_sub = sd_special ? 4'h2 : 4'h1;
    if (cfg.wr_to_rd_gap_cfg > wr_sub) begin
      wr_rd_need = 10'((cfg.wr_to_rd_gap_cfg - wr_sub) * frame_cnt);
    end else begin
      wr_rd_need = 10'h0;
    end
  end

  always_comb begin
    if (cfg.rd_to_wr_gap_cfg == 6'h0) begin
      rd_wr_need = `OCP_RDWR_ZERO;
    end else begin
      rd_wr_need = {4'h0, cfg.rd_to_wr_gap_cfg} + `OCP_RDWR_BASE;
    end
  end

  // ==========================================
  // Sequencer
  ocp_pkg::ocp_state_type state_q;
  ocp_pkg::ocp_req_type req_q;
  logic [1:0] beat_q;
  logic [9:0] since_end_q;
  logic [9:0] need;
  logic start;
  logic last_beat_done;

  assign req_ready = state_q == ocp_pkg::ST_IDLE && cfg.cache_on;
  assign busy = state_q != ocp_pkg::ST_IDLE;

  always_comb begin
    if (req_q.write && !last_write_q) begin
      need = rd_wr_need;
    end else if (!req_q.write && last_write_q) begin
      need = wr_rd_need;
    end else begin
      need = 10'h0;
    end
  end

  // Beats begin only on a cache clock rising edge
  assign start = state_q == ocp_pkg::ST_WAIT && link_rise &&
                 since_end_q >= need;
  assign last_beat_done = state_q == ocp_pkg::ST_BEAT && link_rise &&
                          beat_q == `OCP_LAST_BEAT;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ocp_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        ocp_pkg::ST_IDLE: begin
          if (req_valid && req_ready) begin
            state_q <= ocp_pkg::ST_WAIT;
          end
        end
        ocp_pkg::ST_WAIT: begin
          if (start) begin
            state_q <= ocp_pkg::ST_BEAT;
          end
        end
        ocp_pkg::ST_BEAT: begin
          if (last_beat_done) begin
            state_q <= ocp_pkg::ST_TAIL;
          end
        end
        ocp_pkg::ST_TAIL: begin
          if (link_rise) begin
            state_q <= ocp_pkg::ST_IDLE;
          end
        end
        default: state_q <= ocp_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      req_q <= '0;
    end else if (req_valid && req_ready) begin
      req_q <= req;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      beat_q <= 2'h0;
    end else if (start) begin
      beat_q <= 2'h0;
    end else if (state_q == ocp_pkg::ST_BEAT && link_rise) begin
      beat_q <= beat_q + 2'h1;
    end
  end

  // Cycles since the last beat of the previous transfer
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      since_end_q <= `OCP_SINCE_MAX;
    end else if (last_beat_done) begin
      since_end_q <= 10'h0;
    end else if (since_end_q != `OCP_SINCE_MAX) begin
      since_end_q <= since_end_q + 10'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      last_write_q <= 1'b0;
    end else if (last_beat_done) begin
      last_write_q <= req_q.write;
    end
  end

  // ==========================================
  // Index masking and bank select
  function automatic logic [19:0] mask_index(
    input logic [19:0] idx,
    input logic [3:0] size,
    input logic bank
  );
    logic [19:0] res;
    logic [4:0] used;
    res = idx;
    // Bit i tells whether index bit 15+i is in use
    used = {size, 1'b1};
    for (int i = 0; i < 4; i++) begin
      if (size[i]) begin
        res[16+i] = idx[16+i];
      end else if (bank && used[i]) begin
        res[16+i] = !idx[15+i];
      end else begin
        res[16+i] = 1'b0;
      end
    end
    return res;
  endfunction

  logic [19:0] index_q;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      index_q <= 20'h0;
    end else if (start) begin
      index_q <= mask_index(req_q.index, cfg.cache_size_sel,
                            cfg.bank_split_on);
    end
  end

  assign cache_index_out = index_q;

  // ==========================================
  // Strobe generation
  ocp_pkg::ocp_phase_type phase;

  always_comb begin
    phase.active = state_q == ocp_pkg::ST_BEAT;
    phase.write = req_q.write;
    phase.tail = state_q == ocp_pkg::ST_TAIL;
    phase.beat = beat_q;
  end

  ocp_strobe_gen u_strobe (
    .core_clk(ref_clk),
    .rst_n(rst_n_q),
    .alt_strobe_style(cfg.alt_strobe_style),
    .burst_sel(cfg.burst_sel),
    .phase(phase),
    .strobe(strobe)
  );

  // ==========================================
  // Checks
  sequence s_write_start;
    start && req_q.write && !last_write_q;
  endsequence

  sequence s_read_start;
    start && !req_q.write && last_write_q;
  endsequence

  property p_rd_wr_spacing;
    @(posedge ref_clk) disable iff (!rst_n_q)
      (s_write_start and (cfg.rd_to_wr_gap_cfg != 6'h0))
        |-> since_end_q >= 10'(cfg.rd_to_wr_gap_cfg) + `OCP_RDWR_BASE;
  endproperty
  a_rd_wr_spacing: assert property (p_rd_wr_spacing)
    else $error("read to write spacing too short");

  property p_rd_wr_zero;
    @(posedge ref_clk) disable iff (!rst_n_q)
      (s_write_start and cfg.rd_to_wr_gap_cfg == 6'h0)
        |-> since_end_q >= 10'h040;
  endproperty
  a_rd_wr_zero: assert property (p_rd_wr_zero)
    else $error("zero read to write gap did not give 64 cycles");

  property p_wr_rd_spacing;
    @(posedge ref_clk) disable iff (!rst_n_q)
      (s_read_start and (cfg.dual_data && cfg.wr_to_rd_gap_cfg > 4'h1))
        |-> since_end_q >= 10'((cfg.wr_to_rd_gap_cfg - 4'h1) * cfg.ratio_x2);
  endproperty
  a_wr_rd_spacing: assert property (p_wr_rd_spacing)
    else $error("write to read spacing too short");

  property p_four_beats;
    @(posedge ref_clk) disable iff (!rst_n_q)
      last_beat_done |=> state_q == ocp_pkg::ST_TAIL && since_end_q == 10'h0;
  endproperty
  a_four_beats: assert property (p_four_beats)
    else $error("transfer did not end after fourth beat");

  property p_index_mask;
    @(posedge ref_clk) disable iff (!rst_n_q)
      (!cfg.bank_split_on && $stable(cfg.cache_size_sel) && start)
        |=> (cache_index_out[19:16] & ~cfg.cache_size_sel) == 4'h0;
  endproperty
  a_index_mask: assert property (p_index_mask)
    else $error("index bit above cache size not zero");

  property p_bank_bit;
    @(posedge ref_clk) disable iff (!rst_n_q)
      (cfg.bank_split_on && cfg.cache_size_sel == 4'h0 && start)
        |=> cache_index_out[16] == !cache_index_out[15];
  endproperty
  a_bank_bit: assert property (p_bank_bit)
    else $error("bank bit is not the inverted top index bit");

  property p_off_refuses;
    @(posedge ref_clk) disable iff (!rst_n_q)
      !cfg.cache_on |-> !req_ready;
  endproperty
  a_off_refuses: assert property (p_off_refuses)
    else $error("request accepted with cache off");

  property p_wait_idle;
    @(posedge ref_clk) disable iff (!rst_n_q)
      (state_q == ocp_pkg::ST_WAIT) [*2] |-> strobe.tag_write_n;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("strobe active during gap");

endmodule

`default_nettype wire

// ### sim/ocp_sram_model.sv
// Far-side SRAM stand-in: free-running cache clock, tag access count
`timescale 1ns/10ps
`default_nettype none

module ocp_sram_model (
  // Core clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Pins from the port
  input wire ocp_pkg::ocp_strobe_type strobe,
  // Cache clock and observations
  output logic link_clk,
  output var int tag_hits
);
  logic tag_idle_q;

  // ====================
  // Cache clock, phase unrelated to the core clock
  initial begin
    link_clk = 1'b0;
    #13;
    forever #200 link_clk = ~link_clk;
  end

  // ====================
  // One tag access per transfer, counted where a tag strobe first leaves idle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tag_idle_q <= 1'b1;
      tag_hits <= 0;
    end else begin
      tag_idle_q <= strobe.tag_oe_n & strobe.tag_write_n;
      if (tag_idle_q && !(strobe.tag_oe_n & strobe.tag_write_n)) begin
        tag_hits <= tag_hits + 1;
      end
    end
  end
endmodule

`default_nettype wire

// ### sim/ocp_port_ctrl_tb_top.sv
// Self-checking bench for the cache port control block
`include "ocp_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module ocp_port_ctrl_tb_top;
  localparam int SP_DUAL [6] = '{1, 0, 0, 0, 1, 1};
  localparam int SP_R2 [6] = '{4, 4, 5, 8, 4, 4};
  localparam int SP_WRRD [6] = '{5, 15, 6, 4, 3, 3};
  localparam int SP_RDWR [6] = '{2, 2, 2, 2, 20, 0};
  logic ref_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic req_valid, req_ready, link_clk, busy;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [19:0] cache_index_out, idx_seen;
  ocp_pkg::ocp_req_type req;
  ocp_pkg::ocp_strobe_type strobe;
  logic [4:0] smp [5];
  logic [19:0] exp_q [$];
  int failures = 0, samples_checked = 0, cyc_n = 0, n_txn = 0;
  int tag_hits, t0, t1;
  integer seed = 32'hfb081a1d;

  ocp_port_ctrl ocp_port_ctrl_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .link_clk(link_clk),
    .cache_index_out(cache_index_out), .strobe(strobe), .busy(busy));
  ocp_sram_model ocp_sram_model_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .strobe(strobe), .link_clk(link_clk), .tag_hits(tag_hits));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc_n <= cyc_n + 1;

  // ====================
  // Checking and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ====================
  // Reference model
  function automatic logic [31:0] ctrl(input logic [3:0] size,
      input logic bank, input logic [1:0] sty, input logic dual,
      input logic [3:0] r2, input logic [3:0] wrrd, input logic [5:0] rdwr);
    return {2'h0, rdwr, 4'h0, wrrd, 3'h0, r2, dual, sty, bank, size, 1'b1};
  endfunction

  function automatic logic [4:0] exp_strobe(input logic [1:0] sty,
      input logic wr, input int k);
    logic [24:0] row;
    case ({sty, wr})
      3'b000: row = {5'h15, 5'h17, 5'h17, 5'h17, 5'h1f};
      3'b001: row = {5'h10, 5'h13, 5'h13, 5'h13, 5'h1b};
      3'b010: row = {5'h05, 5'h17, 5'h17, 5'h17, 5'h1b};
      3'b011: row = {5'h00, 5'h13, 5'h13, 5'h13, 5'h13};
      3'b100: row = {5'h1d, 5'h15, 5'h17, 5'h17, 5'h17};
      3'b101: row = {5'h1e, 5'h17, 5'h17, 5'h17, 5'h1f};
      3'b110: row = {5'h0f, 5'h15, 5'h15, 5'h17, 5'h17};
      default: row = {5'h0a, 5'h1b, 5'h1b, 5'h1b, 5'h1f};
    endcase
    return row[24 - 5 * k -: 5];
  endfunction

  function automatic int exp_gap(input int dual, r2, wrrd, rdwr, rw);
    int frm;
    frm = dual ? r2 : (r2 % 4 == 0 ? r2 / 2 : r2);
    if (rw) return rdwr == 0 ? 64 : rdwr + 6;
    if (!dual && r2 == 4) return (wrrd - 2) * frm;
    return (wrrd - 1) * frm;
  endfunction

  // ====================
  // Drivers
  task automatic wb_xfer(input logic we, input logic [3:0] adr,
      input logic [31:0] dat, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Runs one transfer; samples strobes mid-beat and in the tail
  task automatic txn(input logic wr, input logic [19:0] idx, output int t);
    logic [4:0] s0;
    int n;
    n = 0;
    req_valid <= 1'b1;
    req <= {wr, idx};
    do begin
      @(posedge ref_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 400);
    req_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    s0 = strobe;
    do begin
      @(posedge ref_clk);
      n++;
    end while (strobe === s0 && n < 400);
    if (n >= 400) failures++;
    t = cyc_n;
    idx_seen = cache_index_out;
    check(32'(busy), 32'h1);
    for (int k = 0; k < 5; k++) begin
      repeat (k == 0 ? 4 : 8) @(posedge ref_clk);
      smp[k] = strobe;
    end
    n_txn++;
  endtask

  initial begin
    #2_000_000;
    failures++;
    give_verdict();
  end

  // ====================
  // Main sequence
  initial begin
    logic [19:0] idx, em;
    int d, e;
    reset_n = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, req_valid} = 4'h0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    req = '0;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check(32'(strobe), 32'h1f);
    check(32'(cache_index_out), 32'h0);
    check(32'(req_ready), 32'h0);
    check(32'(busy), 32'h0);
    wb_xfer(1'b0, `OCP_ADDR_CTRL, 32'h0, rd);
    check(rd, `OCP_CTRL_RESET);
    wb_xfer(1'b1, 4'hc, 32'hffff_ffff, rd);
    wb_xfer(1'b0, 4'hc, 32'h0, rd);
    check(rd, 32'h0);
    wb_xfer(1'b0, `OCP_ADDR_CTRL, 32'h0, rd);
    check(rd, `OCP_CTRL_RESET);
    $display("test reset done");
    for (int b = 0; b < 2; b++) begin
      for (int k = 0; k < 5; k++) begin
        wb_xfer(1'b1, `OCP_ADDR_CTRL, ctrl(4'((1 << k) - 1), b[0], 2'h0,
          1'b1, 4'h4, 4'h3, 6'h02), rd);
        idx = 20'($random(seed));
        txn(1'b0, idx, t0);
        em = idx & 20'((1 << (16 + k)) - 1);
        if (b == 1 && k < 4) em[16 + k] = ~idx[15 + k];
        exp_q.push_back(em);
        check(32'(idx_seen), 32'(exp_q.pop_front()));
      end
    end
    $display("test index done");
    for (int s = 0; s < 4; s++) begin
      wb_xfer(1'b1, `OCP_ADDR_CTRL, ctrl(4'hf, 1'b0, 2'(s), 1'b1, 4'h4,
        4'h3, 6'h02), rd);
      for (int w = 0; w < 2; w++) begin
        txn(w[0], 20'($random(seed)), t0);
        for (int k = 0; k < 5; k++) begin
          e = 32'(exp_strobe(2'(s), w[0], k));
          check(32'(smp[k]), 32'(e));
        end
        check(32'(tag_hits), 32'(n_txn));
      end
    end
    repeat (16) @(posedge ref_clk);
    wb_xfer(1'b0, `OCP_ADDR_STATUS, 32'h0, rd);
    check(32'(rd[2:0]), 32'h6);
    $display("test strobes done");
    for (int c = 0; c < 6; c++) begin
      wb_xfer(1'b1, `OCP_ADDR_CTRL, ctrl(4'hf, 1'b0, 2'h0, SP_DUAL[c][0],
        4'(SP_R2[c]), 4'(SP_WRRD[c]), 6'(SP_RDWR[c])), rd);
      txn(c < 4, 20'($random(seed)), t0);
      txn(c >= 4, 20'($random(seed)), t1);
      d = t1 - t0 - 32;
      e = exp_gap(SP_DUAL[c], SP_R2[c], SP_WRRD[c], SP_RDWR[c], c >= 4);
      check(32'(d >= e), 32'h1);
      check(32'(d <= e + 12), 32'h1);
    end
    $display("test spacing done");
    give_verdict();
  end
endmodule

`default_nettype wire
